// [verilog/pcg_pkg.sv]
// constants and types shared by the laser pwm command generator
package pcg_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and time units
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned US_PER_S      = 1_000_000;
    localparam int unsigned CYC_PER_US    = CLK_HZ / US_PER_S;

    ////////////////////////////////////////////////////////////////////////////////
    // command waveform times, in their own units
    localparam int unsigned BASE_PERIOD_US    = 200;
    localparam int unsigned MAX_PWM_HZ        = 20_000;
    localparam int unsigned TICKLE_PERIOD_US  = 200;
    localparam int unsigned TICKLE_LEN_US     = 1;
    localparam int unsigned WARMUP_S          = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // derived cycle counts; least times round up
    localparam int unsigned BASE_PERIOD_CYC   = BASE_PERIOD_US * CYC_PER_US;
    localparam int unsigned MIN_PERIOD_CYC    = (CLK_HZ + MAX_PWM_HZ - 1) / MAX_PWM_HZ;
    localparam int unsigned TICKLE_PERIOD_CYC = TICKLE_PERIOD_US * CYC_PER_US;
    localparam int unsigned TICKLE_LEN_CYC    = TICKLE_LEN_US * CYC_PER_US;
    localparam int unsigned WARMUP_CYC        = WARMUP_S * CLK_HZ;

    ////////////////////////////////////////////////////////////////////////////////
    // setting widths and reset values
    localparam int unsigned PERIOD_W          = 32;
    localparam int unsigned DEFAULT_DUTY_CYC  = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // gate input resistor mode
    typedef enum logic {
        PCG_GATE_PULLUP   = 1'b0,
        PCG_GATE_PULLDOWN = 1'b1
    } pcg_gate_mode_t;

    // operating phase of the generator
    typedef enum logic [1:0] {
        PCG_PH_WARMUP  = 2'b00,
        PCG_PH_BLOCKED = 2'b01,
        PCG_PH_PWM     = 2'b10,
        PCG_PH_CW      = 2'b11
    } pcg_phase_t;

endpackage : pcg_pkg

// [verilog/pcg_cycle_timer.sv]
// free-running cycle timer with clear, run enable and one-cycle wrap pulse
`timescale 1ns/100ps
module pcg_cycle_timer #(
    parameter int unsigned LIMIT = 125,
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_clear,
    input  wire logic             i_run,
    output logic                  o_wrap
);

    logic [WIDTH-1:0] count_reg;
    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

    if (LIMIT < 2 || LIMIT > (64'd1 << WIDTH)) begin : g_bad_limit
        $error("pcg_cycle_timer: LIMIT does not fit WIDTH or is below 2");
    end

    assign o_wrap = i_run && !i_clear && (count_reg == LAST);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count_reg <= '0;
        end else if (i_clear || o_wrap) begin
            count_reg <= '0;
        end else if (i_run) begin
            count_reg <= count_reg + WIDTH'(1);
        end
    end

endmodule : pcg_cycle_timer

// [verilog/pcg_laser_pwm_command_gen.sv]
// pwm command generator with tickle, gate and continuous-on modes for an rf-excited laser
`timescale 1ns/100ps
module pcg_laser_pwm_command_gen #(
    parameter int unsigned BASE_PERIOD_CYC   = pcg_pkg::BASE_PERIOD_CYC,
    parameter int unsigned MIN_PERIOD_CYC    = pcg_pkg::MIN_PERIOD_CYC,
    parameter int unsigned TICKLE_PERIOD_CYC = pcg_pkg::TICKLE_PERIOD_CYC,
    parameter int unsigned TICKLE_LEN_CYC    = pcg_pkg::TICKLE_LEN_CYC,
    parameter int unsigned WARMUP_CYC        = pcg_pkg::WARMUP_CYC,
    parameter int unsigned PERIOD_W          = pcg_pkg::PERIOD_W
) (
    input  wire logic                i_clk,
    input  wire logic                i_rstn,
    // user settings
    input  wire logic                i_cfg_load,
    input  wire logic [PERIOD_W-1:0] i_period_cycles,
    input  wire logic [PERIOD_W-1:0] i_duty_cycles,
    input  wire logic                i_cw_mode,
    input  wire logic                i_gate_mode_wr,
    input  wire logic                i_gate_mode_pulldown,
    // gate connector
    input  wire logic                i_gate_level,
    input  wire logic                i_gate_driven,
    // laser side
    output logic                     o_beam_command_out_a,
    output logic                     o_beam_command_out_b,
    output logic                     o_laser_enable,
    // status
    output logic                     o_cfg_reject,
    output logic                     o_cfg_pending,
    output logic                     o_warmup_done,
    output logic                     o_gate_open,
    output logic                     o_gate_pulldown,
    output logic                     o_tickle_active,
    output logic [PERIOD_W-1:0]      o_period_cycles,
    output logic [PERIOD_W-1:0]      o_duty_cycles
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    localparam int unsigned WARM_W   = $clog2(WARMUP_CYC + 1);
    localparam int unsigned TPER_W   = $clog2(TICKLE_PERIOD_CYC + 1);
    localparam int unsigned TLEN_W   = $clog2(TICKLE_LEN_CYC + 1);
    localparam logic [PERIOD_W-1:0] BASE_PERIOD = PERIOD_W'(BASE_PERIOD_CYC);
    localparam logic [PERIOD_W-1:0] MIN_PERIOD  = PERIOD_W'(MIN_PERIOD_CYC);
    localparam logic [PERIOD_W-1:0] DEF_DUTY    = PERIOD_W'(pcg_pkg::DEFAULT_DUTY_CYC);

    if (PERIOD_W < 2 || PERIOD_W > 32) begin : g_bad_width
        $error("pcg_laser_pwm_command_gen: PERIOD_W must be 2 to 32");
    end
    if (MIN_PERIOD_CYC < 2 || BASE_PERIOD_CYC < MIN_PERIOD_CYC) begin : g_bad_period
        $error("pcg_laser_pwm_command_gen: base period below the minimum period");
    end
    if (TICKLE_LEN_CYC < 1 || TICKLE_LEN_CYC >= TICKLE_PERIOD_CYC) begin : g_bad_tickle
        $error("pcg_laser_pwm_command_gen: tickle must be shorter than its period");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    pcg_pkg::pcg_gate_mode_t gate_mode_reg;
    pcg_pkg::pcg_phase_t     phase;
    logic                    warm_done_reg;
    logic                    warm_wrap;
    logic                    gate_open;
    logic [PERIOD_W-1:0]     period_reg;
    logic [PERIOD_W-1:0]     duty_reg;
    logic [PERIOD_W-1:0]     pend_period_reg;
    logic [PERIOD_W-1:0]     pend_duty_reg;
    logic                    pend_valid_reg;
    logic [PERIOD_W-1:0]     pcnt_reg;
    logic                    pwm_run;
    logic                    boundary;
    logic                    apply;
    logic                    cfg_ok;
    logic                    pwm_on;
    logic                    tickle_reg;
    logic                    tickle_start;
    logic                    tickle_end;
    logic                    cmd_reg;
    logic                    cmd_next;
    logic                    reject_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // laser enable, held active since this system has no enable of its own
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_laser_enable <= 1'b1;
        end else begin
            o_laser_enable <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gate resistor mode; software moves to pull-down for production use
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gate_mode_reg <= pcg_pkg::PCG_GATE_PULLUP;
        end else if (i_gate_mode_wr) begin
            gate_mode_reg <= i_gate_mode_pulldown ? pcg_pkg::PCG_GATE_PULLDOWN
                                                  : pcg_pkg::PCG_GATE_PULLUP;
        end
    end

    // an undriven gate reads as the selected resistor would pull it
    always_comb begin
        if (i_gate_driven) begin
            gate_open = i_gate_level;
        end else begin
            gate_open = (gate_mode_reg == pcg_pkg::PCG_GATE_PULLUP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // start-up: tickles only until the warm-up time has run out
    pcg_cycle_timer #(
        .LIMIT (WARMUP_CYC),
        .WIDTH (WARM_W)
    ) u_warmup (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_clear (1'b0),
        .i_run   (!warm_done_reg),
        .o_wrap  (warm_wrap)
    );

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            warm_done_reg <= 1'b0;
        end else if (warm_wrap) begin
            warm_done_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // phase selection: after warm-up, gating decides whether pulses are issued and i_cw_mode picks pwm or continuous-on; tickles go on while closed
    always_comb begin
        if (!warm_done_reg) begin
            phase = pcg_pkg::PCG_PH_WARMUP;
        end else if (!gate_open) begin
            phase = pcg_pkg::PCG_PH_BLOCKED;
        end else if (i_cw_mode) begin
            phase = pcg_pkg::PCG_PH_CW;
        end else begin
            phase = pcg_pkg::PCG_PH_PWM;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // setting intake: too short a period is refused, duty is clamped to it
    assign cfg_ok = (i_period_cycles >= MIN_PERIOD);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            reject_reg <= 1'b0;
        end else begin
            reject_reg <= i_cfg_load && !cfg_ok;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_period_reg <= BASE_PERIOD;
            pend_duty_reg   <= DEF_DUTY;
        end else if (i_cfg_load && cfg_ok) begin
            pend_period_reg <= i_period_cycles;
            pend_duty_reg   <= (i_duty_cycles > i_period_cycles) ? i_period_cycles
                                                                 : i_duty_cycles;
        end
    end

    // a new load wins over the apply of the one before it
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_valid_reg <= 1'b0;
        end else if (i_cfg_load && cfg_ok) begin
            pend_valid_reg <= 1'b1;
        end else if (apply) begin
            pend_valid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // period counter and active settings
    assign pwm_run  = (phase == pcg_pkg::PCG_PH_PWM);
    assign boundary = pwm_run && (pcnt_reg == period_reg - PERIOD_W'(1));
    assign apply    = pend_valid_reg && (!pwm_run || boundary);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pcnt_reg <= '0;
        end else if (!pwm_run || boundary) begin
            pcnt_reg <= '0;
        end else begin
            pcnt_reg <= pcnt_reg + PERIOD_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            period_reg <= BASE_PERIOD;
            duty_reg   <= DEF_DUTY;
        end else if (apply) begin
            period_reg <= pend_period_reg;
            duty_reg   <= pend_duty_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // raw pwm level for this cycle
    always_comb begin
        case (phase)
            pcg_pkg::PCG_PH_WARMUP:  pwm_on = 1'b0;
            pcg_pkg::PCG_PH_BLOCKED: pwm_on = 1'b0;
            pcg_pkg::PCG_PH_PWM:     pwm_on = (pcnt_reg < duty_reg);
            pcg_pkg::PCG_PH_CW:      pwm_on = 1'b1;
            default:                 pwm_on = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tickle generation while the command is low; the interval restarts
    // whenever pwm is high, so the first tickle lands one period after the fall
    pcg_cycle_timer #(
        .LIMIT (TICKLE_PERIOD_CYC),
        .WIDTH (TPER_W)
    ) u_tickle_period (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_clear (pwm_on),
        .i_run   (1'b1),
        .o_wrap  (tickle_start)
    );

    pcg_cycle_timer #(
        .LIMIT (TICKLE_LEN_CYC),
        .WIDTH (TLEN_W)
    ) u_tickle_len (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_clear (pwm_on || tickle_start),
        .i_run   (tickle_reg),
        .o_wrap  (tickle_end)
    );

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tickle_reg <= 1'b0;
        end else if (pwm_on) begin
            tickle_reg <= 1'b0;
        end else if (tickle_start) begin
            tickle_reg <= 1'b1;
        end else if (tickle_end) begin
            tickle_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command output: one flop feeds both connectors
    assign cmd_next = pwm_on || tickle_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_reg <= 1'b0;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    assign o_beam_command_out_a = cmd_reg;
    assign o_beam_command_out_b = cmd_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // status
    assign o_cfg_reject    = reject_reg;
    assign o_cfg_pending   = pend_valid_reg;
    assign o_warmup_done   = warm_done_reg;
    assign o_gate_open     = gate_open;
    assign o_gate_pulldown = (gate_mode_reg == pcg_pkg::PCG_GATE_PULLDOWN);
    assign o_tickle_active = tickle_reg;
    assign o_period_cycles = period_reg;
    assign o_duty_cycles   = duty_reg;

endmodule : pcg_laser_pwm_command_gen

// [verification/pcg_laser_pwm_command_gen_chk.sv]
// concurrent checks on the command generator ports
`timescale 1ns/100ps
module pcg_cmd_chk #(
    parameter int unsigned MIN_PERIOD_CYC = 20,
    parameter int unsigned PERIOD_W       = 32
) (
    input wire logic                i_clk,
    input wire logic                i_rstn,
    input wire logic                i_cfg_load,
    input wire logic [PERIOD_W-1:0] i_period_cycles,
    input wire logic                i_cw_mode,
    input wire logic                i_gate_mode_wr,
    input wire logic                i_gate_mode_pulldown,
    input wire logic                i_gate_driven,
    input wire logic                o_beam_command_out_a,
    input wire logic                o_beam_command_out_b,
    input wire logic                o_laser_enable,
    input wire logic                o_cfg_reject,
    input wire logic                o_cfg_pending,
    input wire logic                o_warmup_done,
    input wire logic                o_gate_open,
    input wire logic                o_gate_pulldown,
    input wire logic                o_tickle_active,
    input wire logic [PERIOD_W-1:0] o_period_cycles,
    input wire logic [PERIOD_W-1:0] o_duty_cycles
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_cmd_copies: assert property (o_beam_command_out_a == o_beam_command_out_b)
        else $error("command outputs differ");
    a_enable_held: assert property (o_laser_enable)
        else $error("laser enable dropped");
    a_no_early_pwm: assert property (
        o_beam_command_out_a && !o_warmup_done |-> $past(o_tickle_active))
        else $error("command pulse before warm-up ends");
    // pulse length matches the bench's shortened tickle length of 3
    a_tickle_len: assert property (
        $rose(o_tickle_active) && !o_warmup_done
        |-> o_tickle_active [*3] ##1 !o_tickle_active)
        else $error("tickle length wrong");
    a_tickle_out: assert property (o_tickle_active |=> o_beam_command_out_a)
        else $error("tickle not on command");
    a_cfg_refused: assert property (
        i_cfg_load && i_period_cycles < MIN_PERIOD_CYC && !o_cfg_pending
        |=> o_cfg_reject && $stable(o_period_cycles))
        else $error("fast period not refused");
    a_cfg_waits: assert property (
        i_cfg_load && i_period_cycles >= MIN_PERIOD_CYC |=> o_cfg_pending)
        else $error("accepted setting not pending");
    a_gate_blocks: assert property (
        !o_gate_open && !o_tickle_active |=> !o_beam_command_out_a)
        else $error("closed gate left command high");
    a_cw_steady: assert property (
        o_warmup_done && i_cw_mode && o_gate_open |=> o_beam_command_out_a)
        else $error("continuous-on command low");
    a_mode_write: assert property (
        i_gate_mode_wr |=> o_gate_pulldown == $past(i_gate_mode_pulldown))
        else $error("gate mode not written");
    a_pull_level: assert property (!i_gate_driven |-> o_gate_open == !o_gate_pulldown)
        else $error("open gate level wrong");
    a_duty_clamp: assert property (o_duty_cycles <= o_period_cycles)
        else $error("duty above period");
endmodule : pcg_cmd_chk

bind pcg_laser_pwm_command_gen pcg_cmd_chk #(.MIN_PERIOD_CYC(MIN_PERIOD_CYC), .PERIOD_W(PERIOD_W)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_cfg_load(i_cfg_load), .i_period_cycles(i_period_cycles),
    .i_cw_mode(i_cw_mode), .i_gate_mode_wr(i_gate_mode_wr),
    .i_gate_mode_pulldown(i_gate_mode_pulldown), .i_gate_driven(i_gate_driven),
    .o_beam_command_out_a(o_beam_command_out_a), .o_beam_command_out_b(o_beam_command_out_b),
    .o_laser_enable(o_laser_enable), .o_cfg_reject(o_cfg_reject), .o_cfg_pending(o_cfg_pending),
    .o_warmup_done(o_warmup_done), .o_gate_open(o_gate_open), .o_gate_pulldown(o_gate_pulldown),
    .o_tickle_active(o_tickle_active), .o_period_cycles(o_period_cycles),
    .o_duty_cycles(o_duty_cycles));

// [verification/pcg_laser_model.sv]
// behavioural model of the laser's two command inputs
`timescale 1ns/100ps
module pcg_laser_model (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_cmd_a,
    input  wire logic        i_cmd_b,
    input  wire logic        i_enable,
    output logic [15:0]      o_high_len,
    output logic [15:0]      o_pulses,
    output logic             o_mismatch
);
    logic [15:0] run_reg;
    logic        beam_on;

    // beam only while enabled and commanded high
    assign beam_on = i_enable & i_cmd_a;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            run_reg    <= 16'h0;
            o_high_len <= 16'h0;
            o_pulses   <= 16'h0;
            o_mismatch <= 1'b0;
        end else begin
            if (i_cmd_a !== i_cmd_b) begin
                o_mismatch <= 1'b1;
            end
            if (beam_on) begin
                run_reg <= run_reg + 16'h1;
            end else begin
                run_reg <= 16'h0;
            end
            if (!beam_on && run_reg != 16'h0) begin
                o_high_len <= run_reg;
            end
            if (beam_on && run_reg == 16'h0) begin
                o_pulses <= o_pulses + 16'h1;
            end
        end
    end
endmodule : pcg_laser_model

// [verification/laser_pwm_command_gen_bench.sv]
// self-checking bench for the laser pwm command generator
`timescale 1ns/100ps
module laser_pwm_command_gen_bench;
    localparam int P_TICK = 50;
    logic        i_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        ld = 1'b0, cw = 1'b0, mwr = 1'b0, mpd = 1'b0, glv = 1'b0, gdr = 1'b0;
    logic [31:0] per = 32'h0, dut = 32'h0, per_o, dut_o;
    logic        ca, cb, len, rej, pend, warm, gop, gpd, tick, mism;
    logic [15:0] hi_len, pulses;
    int          errors = 0;
    int          n_tests = 0;
    int          since_rel = 0;

    pcg_laser_pwm_command_gen #(.BASE_PERIOD_CYC(40), .MIN_PERIOD_CYC(20), .TICKLE_PERIOD_CYC(50),
        .TICKLE_LEN_CYC(3), .WARMUP_CYC(200)) uut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_cfg_load(ld), .i_period_cycles(per),
        .i_duty_cycles(dut), .i_cw_mode(cw), .i_gate_mode_wr(mwr), .i_gate_mode_pulldown(mpd),
        .i_gate_level(glv), .i_gate_driven(gdr), .o_beam_command_out_a(ca),
        .o_beam_command_out_b(cb), .o_laser_enable(len), .o_cfg_reject(rej),
        .o_cfg_pending(pend), .o_warmup_done(warm), .o_gate_open(gop), .o_gate_pulldown(gpd),
        .o_tickle_active(tick), .o_period_cycles(per_o), .o_duty_cycles(dut_o));
    pcg_laser_model u_laser (.i_clk(i_clk), .i_rstn(i_rstn), .i_cmd_a(ca), .i_cmd_b(cb),
        .i_enable(len), .o_high_len(hi_len), .o_pulses(pulses), .o_mismatch(mism));

    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (i_rstn) begin
            since_rel <= since_rel + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            errors++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    // cycles until the command next reaches lvl after leaving it
    task automatic to_level(input logic lvl, output int n);
        n = 0;
        while (ca === lvl && n < 2000) begin
            cyc(1);
            n++;
        end
        while (ca !== lvl && n < 2000) begin
            cyc(1);
            n++;
        end
    endtask : to_level
    task automatic load(input logic [31:0] p, input logic [31:0] d, input int settle);
        per = p;
        dut = d;
        ld = 1'b1;
        cyc(1);
        ld = 1'b0;
        while (settle > 0 && pend === 1'b1) begin
            cyc(1);
            settle--;
        end
    endtask : load
    task automatic set_mode(input logic pd);
        mpd = pd;
        mwr = 1'b1;
        cyc(1);
        mwr = 1'b0;
    endtask : set_mode

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_warmup;
        int n, h;
        check(per_o === 32'h28 && dut_o === 32'h0, "period or duty after reset");
        check(gpd === 1'b0 && gop === 1'b1 && len === 1'b1, "gate mode or enable");
        check(ca === 1'b0 && warm === 1'b0, "command after reset");
        to_level(1'b1, n);
        check(since_rel >= P_TICK && since_rel <= P_TICK + 3, "first tickle");
        to_level(1'b0, n);
        check(n == 3, "tickle length");
        to_level(1'b1, h);
        check(n + h == P_TICK, "tickle spacing");
        while (warm !== 1'b1 && since_rel < 1000) begin
            cyc(1);
        end
        check(since_rel >= 200 && since_rel <= 202, "warm-up length");
    endtask : t_reset_and_warmup
    task automatic t_settings;
        int n;
        logic [15:0] k;
        load(32'h13, 32'h5, 0);
        check(rej === 1'b1 && per_o === 32'h28, "fast period accepted");
        cyc(1);
        check(rej === 1'b0, "reject longer than a cycle");
        load(32'h28, 32'hA, 200);
        check(per_o === 32'h28 && dut_o === 32'hA, "setting not applied");
        to_level(1'b1, n);
        to_level(1'b0, n);
        check(n == 10, "high time");
        to_level(1'b1, n);
        check(n == 30, "low time");
        load(32'h3C, 32'h1E, 0);
        check(pend === 1'b1 && per_o === 32'h28, "setting applied mid-period");
        to_level(1'b0, n);
        check(n + 1 == 10, "pulse cut by new setting");
        load(32'h3C, 32'h1E, 200);
        check(per_o === 32'h3C, "new period");
        to_level(1'b1, n);
        to_level(1'b0, n);
        check(n == 30, "new high time");
        load(32'h28, 32'h64, 200);
        check(dut_o === 32'h28, "duty not clamped");
        cyc(2);
        k = pulses;
        cyc(90);
        check(pulses === k && ca === 1'b1, "full duty not steady");
        load(32'h28, 32'hA, 200);
    endtask : t_settings
    task automatic t_gate;
        int n;
        set_mode(1'b1);
        check(gpd === 1'b1 && gop === 1'b0, "pull-down open gate");
        cyc(2);
        check(ca === 1'b0, "beam not blocked");
        gdr = 1'b1;
        glv = 1'b1;
        to_level(1'b1, n);
        check(n <= 2, "gate opening slow");
        to_level(1'b0, n);
        check(n == 10, "period not restarted");
        glv = 1'b0;
        cyc(2);
        check(ca === 1'b0, "low gate not blocking");
        to_level(1'b1, n);
        check(n >= P_TICK - 4 && n <= P_TICK + 2, "tickle after fall");
        to_level(1'b0, n);
        cyc(1);
        check(hi_len === 16'h3, "tickle width at laser");
    endtask : t_gate
    task automatic t_cw;
        int n;
        logic [15:0] k;
        cw = 1'b1;
        glv = 1'b1;
        cyc(3);
        k = pulses;
        cyc(50);
        load(32'h28, 32'h5, 0);
        cyc(50);
        check(pulses === k && ca === 1'b1, "continuous-on broken");
        glv = 1'b0;
        cyc(2);
        check(ca === 1'b0, "continuous-on not gated");
        to_level(1'b1, n);
        check(n >= P_TICK - 2 && n <= P_TICK + 4, "no tickle in continuous-on");
        cw = 1'b0;
        set_mode(1'b0);
        gdr = 1'b0;
        cyc(1);
        check(gop === 1'b1 && mism === 1'b0, "pull-up restore or copies");
    endtask : t_cw

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (16) @(negedge i_clk);
        i_rstn = 1'b1;
        t_reset_and_warmup();
        t_settings();
        t_gate();
        t_cw();
        tally_and_finish();
    end
    initial begin
        #160000;
        errors++;
        $display("wrong value at %0t ns: run did not end", $time);
        tally_and_finish();
    end
endmodule : laser_pwm_command_gen_bench
